// ### sss_pkg.sv
package sss_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ            = 200_000_000;
  localparam int unsigned CUR_DELAY_MS      = 50;
  localparam int unsigned ATTEMPT_GAP_MS    = 100;
  localparam int unsigned CUR_DELAY_CYC     = CLK_HZ / 1000 * CUR_DELAY_MS;
  localparam int unsigned ATTEMPT_GAP_CYC   = CLK_HZ / 1000 * ATTEMPT_GAP_MS;

  // ----------------------------------------
  // register map (byte addresses, byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] REG_AXIS_SEL   = 8'h00;
  localparam logic [7:0] REG_CTRL       = 8'h04;
  localparam logic [7:0] REG_START_SPD  = 8'h08;
  localparam logic [7:0] REG_STEPS_REV  = 8'h0c;
  localparam logic [7:0] REG_MOT_LIMIT  = 8'h10;
  localparam logic [7:0] REG_STILL_LIM  = 8'h14;
  localparam logic [7:0] REG_MAX_TRIES  = 8'h18;
  localparam logic [7:0] REG_LINES      = 8'h1c;
  localparam logic [7:0] REG_CUR_DELAY  = 8'h20;
  localparam logic [7:0] REG_TRY_GAP    = 8'h24;
  localparam logic [7:0] REG_CMD_POS    = 8'h28;
  localparam logic [7:0] REG_ENC_POS    = 8'h2c;
  localparam logic [7:0] REG_STATUS     = 8'h30;
  localparam logic [7:0] REG_MOVE       = 8'h34;

  // ctrl field positions
  localparam int CTRL_STILL_LSB = 0;
  localparam int CTRL_BOOST_BIT = 2;
  localparam int CTRL_ACT_LSB   = 3;
  localparam int CTRL_DIR_BIT   = 5;
  localparam int CTRL_WIND_BIT  = 6;
  localparam int CTRL_CLOSED_BIT= 7;

  // ----------------------------------------
  // reset values (positions in counts, speeds in milli-units/s)
  // ----------------------------------------
  localparam int unsigned NUM_AXES          = 8;
  localparam logic [31:0] RST_START_SPD     = 32'h0000_05dc;  // 1.5 units/s in milli-units
  localparam logic [31:0] RST_STEPS_REV     = 32'h0000_07d0;  // 2000
  localparam logic [31:0] RST_MOT_LIMIT     = 32'h0000_0064;  // 0.05 rev of 2000 counts
  localparam logic [31:0] RST_STILL_LIM     = 32'h0000_000a;  // 0.005 rev of 2000 counts
  localparam logic [7:0]  RST_MAX_TRIES     = 8'h0a;          // 10
  localparam logic [15:0] RST_LINES         = 16'h01f4;       // 500
  localparam logic [31:0] RST_CUR_DELAY     = 32'(CUR_DELAY_CYC);
  localparam logic [31:0] RST_TRY_GAP       = 32'(ATTEMPT_GAP_CYC);

  typedef enum logic [1:0] {SSS_STILL_FULL, SSS_STILL_HALF, SSS_STILL_OFF} sss_still_type;
  typedef enum logic [1:0] {SSS_ACT_IGNORE, SSS_ACT_STOP, SSS_ACT_CORRECT, SSS_ACT_RESTART} sss_act_type;
  typedef enum logic [1:0] {SSS_CUR_HALF, SSS_CUR_FULL, SSS_CUR_BOOST, SSS_CUR_OFF} sss_cur_type;
  typedef enum logic [2:0] {SSS_IDLE, SSS_MOVE, SSS_SETTLE, SSS_GAP, SSS_FIX, SSS_FAULT} sss_mode_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sss_bus_type;

  typedef struct packed {
    logic [1:0]  still;
    logic        boost;
    logic [1:0]  act;
    logic        enc_rev;
    logic        wind;
    logic        closed;
    logic [31:0] start_spd;
    logic [31:0] steps_rev;
    logic [31:0] mot_limit;
    logic [31:0] still_lim;
    logic [7:0]  max_tries;
    logic [15:0] lines;
    logic [31:0] cur_delay;
    logic [31:0] try_gap;
  } sss_cfg_type;

endpackage

// ### sss_quad.sv
`timescale 1ns/1ps
module sss_quad
  import sss_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic        rev,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  output logic [31:0]      pos
);

  typedef struct packed {
    logic [2:0]  sa;
    logic [2:0]  sb;
    logic        pa;
    logic        pb;
    logic [31:0] pos;
  } sss_quad_type;

  sss_quad_type r;
  sss_quad_type next_r;
  logic         a_new;
  logic         b_new;
  logic         step;
  logic         up;

  // ----------------------------------------
  // three-stage sync, accept once stages two and three agree
  // ----------------------------------------
  always_comb begin
    next_r       = r;
    next_r.sa    = {r.sa[1:0], enc_a};
    next_r.sb    = {r.sb[1:0], enc_b};
    a_new        = (r.sa[1] == r.sa[2]) ? r.sa[2] : r.pa;
    b_new        = (r.sb[1] == r.sb[2]) ? r.sb[2] : r.pb;
    next_r.pa    = a_new;
    next_r.pb    = b_new;
    // every edge of either channel counts: four counts per line
    step         = (a_new ^ r.pa) ^ (b_new ^ r.pb);
    up           = (a_new ^ r.pb) ^ rev;
    if (load) begin
      next_r.pos = load_val;
    end else if (step) begin
      next_r.pos = up ? r.pos + 32'h1 : r.pos - 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pos = r.pos;

endmodule

// ### sss_axis.sv
`timescale 1ns/1ps
//
// Contract
// - standstill current full, half or off
// - motion current normal or boosted 150%
// - wait settling delay after current change (here only cur_ready flags it; moves are not held)
// - programmable starting speed, default 1.5
// - steps per revolution, default 2000
// - stall when position error exceeds limit
// - action 0 ignores stalls
// - action 1 stops and records fault
// - stop-on-error fault drives fault output
// - action 2 issues correction moves
// - correction limit exceeded stops with error
// - action 3 returns to start, repeats move
// - restart counts attempts, limit raises fault
// - attempt limit programmable, default 10
// - programmable gap between attempts, default 0.1s
// - standstill error limit, default 0.005
// - quadrature four counts per line, 500
// - direction setting inverts count sign
// - stall action changeable while running
// - boost output only during motion
// - reduction gives half current at standstill
// - error is commanded minus encoder
// - settings held per axis, eight axes
module sss_axis
  import sss_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 bus_wr,
  input  wire logic                 bus_rd,
  input  wire logic [7:0]           bus_addr,
  input  wire logic [31:0]          bus_wdata,
  output logic [31:0]               bus_rdata,
  input  wire logic [NUM_AXES-1:0]  enc_a,
  input  wire logic [NUM_AXES-1:0]  enc_b,
  input  wire logic [NUM_AXES-1:0]  step_done,
  output logic [NUM_AXES-1:0]       move_req,
  output logic [NUM_AXES*32-1:0]    move_target,
  output logic [NUM_AXES*32-1:0]    move_start_spd,
  output logic [NUM_AXES*32-1:0]    move_steps_rev,
  output logic [NUM_AXES*2-1:0]     cur_level,
  output logic [NUM_AXES-1:0]       boost_out,
  output logic [NUM_AXES-1:0]       winding_enable,
  output logic [NUM_AXES-1:0]       cur_ready,
  output logic                      fault
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sss_cfg_type  cfg;
    sss_mode_type mode;
    sss_cur_type  cur;
    logic [31:0]  dly;
    logic [31:0]  cmd_pos;
    logic [31:0]  start_pos;
    logic [31:0]  target;
    logic [31:0]  dest;
    logic [7:0]   tries;
    logic         err;
    logic         req;
  } sss_ax_type;

  typedef struct packed {
    logic [2:0]  sel;
    logic [31:0] rdata;
  } sss_top_type;

  sss_ax_type  ax      [NUM_AXES];
  sss_ax_type  next_ax [NUM_AXES];
  sss_top_type t;
  sss_top_type next_t;
  logic [31:0] enc_pos [NUM_AXES];
  logic [NUM_AXES-1:0] enc_load;

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : gq
      sss_quad u_quad (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .enc_a    (enc_a[g]),
        .enc_b    (enc_b[g]),
        .rev      (ax[g].cfg.enc_rev),
        .load     (enc_load[g]),
        .load_val (ax[g].cmd_pos),
        .pos      (enc_pos[g])
      );
      assign move_req[g]                = ax[g].req;
      assign move_target[g*32 +: 32]    = ax[g].dest;
      assign move_start_spd[g*32 +: 32] = ax[g].cfg.start_spd;
      assign move_steps_rev[g*32 +: 32] = ax[g].cfg.steps_rev;
      assign cur_level[g*2 +: 2]        = ax[g].cur;
      assign boost_out[g]               = (ax[g].cur == SSS_CUR_BOOST);
      assign winding_enable[g]          = ax[g].cfg.wind && (ax[g].cur != SSS_CUR_OFF);
      assign cur_ready[g]               = (ax[g].dly == 32'h0);
    end
  endgenerate

  function automatic sss_cur_type want_cur(input sss_ax_type a);
    logic moving;
    moving = (a.mode == SSS_MOVE) || (a.mode == SSS_FIX);
    if (moving) begin
      want_cur = a.cfg.boost ? SSS_CUR_BOOST : SSS_CUR_FULL;
    end else if (a.cfg.still == SSS_STILL_OFF) begin
      want_cur = SSS_CUR_OFF;
    end else if (a.cfg.still == SSS_STILL_HALF) begin
      want_cur = SSS_CUR_HALF;
    end else begin
      want_cur = SSS_CUR_FULL;
    end
  endfunction

  function automatic logic [31:0] absv(input logic [31:0] v);
    absv = v[31] ? (32'h0 - v) : v;
  endfunction

  // ----------------------------------------
  // per-axis logic and register bus
  // ----------------------------------------
  always_comb begin
    logic [31:0] perr;
    logic        stall;
    logic        still_bad;
    logic        sel_hit;
    sss_cur_type wc;
    perr      = 32'h0;
    stall     = 1'b0;
    still_bad = 1'b0;
    sel_hit   = 1'b0;
    wc        = SSS_CUR_FULL;
    next_t    = t;
    enc_load  = '0;
    next_t.rdata = 32'h0;
    for (int i = 0; i < NUM_AXES; i++) begin
      next_ax[i]     = ax[i];
      next_ax[i].req = 1'b0;
      sel_hit        = (t.sel == 3'(i));
      perr           = ax[i].cmd_pos - enc_pos[i];
      stall          = ax[i].cfg.closed && (absv(perr) > ax[i].cfg.mot_limit);
      still_bad      = ax[i].cfg.closed && (absv(perr) > ax[i].cfg.still_lim);
      // current mode change reloads the settling delay; cur_ready shows its end, motion is not held
      wc = want_cur(ax[i]);
      if (wc != ax[i].cur) begin
        next_ax[i].cur = wc;
        next_ax[i].dly = ax[i].cfg.cur_delay;
      end else if (ax[i].dly != 32'h0) begin
        next_ax[i].dly = ax[i].dly - 32'h1;
      end
      // action is read live each cycle, so software may change it mid-move
      case (ax[i].mode)
        SSS_MOVE: begin
          next_ax[i].cmd_pos = enc_pos[i] + perr;
          if (stall && ax[i].cfg.act == SSS_ACT_STOP) begin
            next_ax[i].mode = SSS_FAULT;
            next_ax[i].err  = 1'b1;
          end else if (stall && (ax[i].cfg.act == SSS_ACT_CORRECT || ax[i].cfg.act == SSS_ACT_RESTART)) begin
            if (ax[i].tries >= ax[i].cfg.max_tries) begin
              next_ax[i].mode = SSS_FAULT;
              next_ax[i].err  = 1'b1;
            end else begin
              next_ax[i].tries = ax[i].tries + 8'h1;
              next_ax[i].mode  = SSS_GAP;
              next_ax[i].dly   = ax[i].cfg.try_gap;
            end
          end else if (step_done[i]) begin
            // stall ignored in action 0: move ends open loop
            next_ax[i].mode  = SSS_SETTLE;
          end
        end
        SSS_SETTLE: begin
          if (still_bad && ax[i].cfg.act == SSS_ACT_CORRECT) begin
            if (ax[i].tries >= ax[i].cfg.max_tries) begin
              next_ax[i].mode = SSS_FAULT;
              next_ax[i].err  = 1'b1;
            end else begin
              next_ax[i].tries = ax[i].tries + 8'h1;
              next_ax[i].mode  = SSS_GAP;
              next_ax[i].dly   = ax[i].cfg.try_gap;
            end
          end else begin
            next_ax[i].tries = 8'h0;
            next_ax[i].mode  = SSS_IDLE;
          end
        end
        SSS_GAP: begin
          if (ax[i].dly == 32'h0) begin
            if (ax[i].cfg.act == SSS_ACT_RESTART) begin
              // return to start, then the move is repeated
              next_ax[i].dest = ax[i].start_pos;
              next_ax[i].mode = SSS_FIX;
              next_ax[i].req  = 1'b1;
            end else begin
              // reissue the move to the original target; the commanded position is left as it is
              next_ax[i].dest = ax[i].target;
              next_ax[i].mode = SSS_FIX;
              next_ax[i].req  = 1'b1;
            end
          end
        end
        SSS_FIX: begin
          if (step_done[i]) begin
            if (ax[i].cfg.act == SSS_ACT_RESTART && ax[i].target != ax[i].start_pos) begin
              next_ax[i].mode = SSS_MOVE;
              next_ax[i].dest = ax[i].target;
              next_ax[i].req  = 1'b1;
            end else begin
              next_ax[i].mode = SSS_SETTLE;
            end
          end
        end
        default: begin
        end
      endcase
      if (ax[i].mode == SSS_GAP && ax[i].dly == 32'h0 && ax[i].cfg.act == SSS_ACT_CORRECT) begin
        enc_load[i] = 1'b0;
      end
      if (bus_wr && sel_hit) begin
        if (bus_addr == REG_CTRL) begin
          next_ax[i].cfg.still   = bus_wdata[CTRL_STILL_LSB +: 2];
          next_ax[i].cfg.boost   = bus_wdata[CTRL_BOOST_BIT];
          next_ax[i].cfg.act     = bus_wdata[CTRL_ACT_LSB +: 2];
          next_ax[i].cfg.enc_rev = bus_wdata[CTRL_DIR_BIT];
          next_ax[i].cfg.wind    = bus_wdata[CTRL_WIND_BIT];
          next_ax[i].cfg.closed  = bus_wdata[CTRL_CLOSED_BIT];
        end else if (bus_addr == REG_START_SPD) begin
          next_ax[i].cfg.start_spd = bus_wdata;
        end else if (bus_addr == REG_STEPS_REV) begin
          next_ax[i].cfg.steps_rev = bus_wdata;
        end else if (bus_addr == REG_MOT_LIMIT) begin
          next_ax[i].cfg.mot_limit = bus_wdata;
        end else if (bus_addr == REG_STILL_LIM) begin
          next_ax[i].cfg.still_lim = bus_wdata;
        end else if (bus_addr == REG_MAX_TRIES) begin
          next_ax[i].cfg.max_tries = bus_wdata[7:0];
        end else if (bus_addr == REG_LINES) begin
          next_ax[i].cfg.lines = bus_wdata[15:0];
        end else if (bus_addr == REG_CUR_DELAY) begin
          next_ax[i].cfg.cur_delay = bus_wdata;
        end else if (bus_addr == REG_TRY_GAP) begin
          next_ax[i].cfg.try_gap = bus_wdata;
        end else if (bus_addr == REG_CMD_POS) begin
          next_ax[i].cmd_pos = bus_wdata;
        end else if (bus_addr == REG_ENC_POS) begin
          enc_load[i] = 1'b1;
        end else if (bus_addr == REG_STATUS) begin
          // writing clears a latched fault and idles the axis;
          // a fault raised in this same cycle outlives the clear
          if (!next_ax[i].err || ax[i].err) begin
            next_ax[i].err  = 1'b0;
            next_ax[i].mode = SSS_IDLE;
          end
        end else if (bus_addr == REG_MOVE) begin
          next_ax[i].start_pos = ax[i].cmd_pos;
          next_ax[i].target    = bus_wdata;
          next_ax[i].dest      = bus_wdata;
          next_ax[i].cmd_pos   = bus_wdata;
          next_ax[i].tries     = 8'h0;
          next_ax[i].mode      = SSS_MOVE;
          next_ax[i].req       = 1'b1;
        end
      end
      if (bus_rd && sel_hit) begin
        if (bus_addr == REG_CTRL) begin
          next_t.rdata = {24'h0, ax[i].cfg.closed, ax[i].cfg.wind, ax[i].cfg.enc_rev,
                          ax[i].cfg.act, ax[i].cfg.boost, ax[i].cfg.still};
        end else if (bus_addr == REG_START_SPD) begin
          next_t.rdata = ax[i].cfg.start_spd;
        end else if (bus_addr == REG_STEPS_REV) begin
          next_t.rdata = ax[i].cfg.steps_rev;
        end else if (bus_addr == REG_MOT_LIMIT) begin
          next_t.rdata = ax[i].cfg.mot_limit;
        end else if (bus_addr == REG_STILL_LIM) begin
          next_t.rdata = ax[i].cfg.still_lim;
        end else if (bus_addr == REG_MAX_TRIES) begin
          next_t.rdata = {24'h0, ax[i].cfg.max_tries};
        end else if (bus_addr == REG_LINES) begin
          next_t.rdata = {16'h0, ax[i].cfg.lines};
        end else if (bus_addr == REG_CUR_DELAY) begin
          next_t.rdata = ax[i].cfg.cur_delay;
        end else if (bus_addr == REG_TRY_GAP) begin
          next_t.rdata = ax[i].cfg.try_gap;
        end else if (bus_addr == REG_CMD_POS) begin
          next_t.rdata = ax[i].cmd_pos;
        end else if (bus_addr == REG_ENC_POS) begin
          next_t.rdata = enc_pos[i];
        end else if (bus_addr == REG_STATUS) begin
          next_t.rdata = {16'h0, ax[i].tries, 1'b0, ax[i].dly == 32'h0, ax[i].cur,
                          ax[i].err, ax[i].mode};
        end
      end
    end
    if (bus_wr && bus_addr == REG_AXIS_SEL) begin
      next_t.sel = bus_wdata[2:0];
    end
    if (bus_rd && bus_addr == REG_AXIS_SEL) begin
      next_t.rdata = {29'h0, t.sel};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t <= '0;
      for (int i = 0; i < NUM_AXES; i++) begin
        ax[i]               <= '0;
        ax[i].cur           <= SSS_CUR_FULL;
        ax[i].cfg.start_spd <= RST_START_SPD;
        ax[i].cfg.steps_rev <= RST_STEPS_REV;
        ax[i].cfg.mot_limit <= RST_MOT_LIMIT;
        ax[i].cfg.still_lim <= RST_STILL_LIM;
        ax[i].cfg.max_tries <= RST_MAX_TRIES;
        ax[i].cfg.lines     <= RST_LINES;
        ax[i].cfg.cur_delay <= RST_CUR_DELAY;
        ax[i].cfg.try_gap   <= RST_TRY_GAP;
      end
    end else begin
      t <= next_t;
      for (int i = 0; i < NUM_AXES; i++) begin
        ax[i] <= next_ax[i];
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    fault = 1'b0;
    for (int i = 0; i < NUM_AXES; i++) begin
      fault = fault | ax[i].err;
    end
  end

  assign bus_rdata = t.rdata;

endmodule

// ### sss_axis_properties.sv
`timescale 1ns/1ps
module sss_axis_props
  import sss_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  bus_wr,
  input wire logic                  bus_rd,
  input wire logic [7:0]            bus_addr,
  input wire logic [31:0]           bus_rdata,
  input wire logic [NUM_AXES-1:0]   move_req,
  input wire logic [NUM_AXES*2-1:0] cur_level,
  input wire logic [NUM_AXES-1:0]   boost_out,
  input wire logic [NUM_AXES-1:0]   cur_ready,
  input wire logic                  fault
);
  // ----------------------------------------
  // port properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data outside read slot");
  a_boost_out: assert property (boost_out[0] |-> cur_level[1:0] == SSS_CUR_BOOST)
    else $error("boost output without boost level");
  a_boost_level: assert property (cur_level[1:0] == SSS_CUR_BOOST |-> boost_out[0])
    else $error("boost level without boost output");
  a_boost_axis: assert property (boost_out[7] == (cur_level[15:14] == SSS_CUR_BOOST))
    else $error("last axis boost mismatch");
  a_move_pulse: assert property (move_req[0] |=> !move_req[0])
    else $error("move request longer than one cycle");
  a_fault_latch: assert property (fault && !(bus_wr && bus_addr == REG_STATUS) |=> fault)
    else $error("fault dropped without clear");
  a_ready_drop: assert property ($changed(cur_level[1:0]) |-> ##[0:1] !cur_ready[0])
    else $error("current change without settling");
  a_ready_rise: assert property ($rose(cur_ready[0]) |-> $stable(cur_level[1:0]))
    else $error("ready rose during level change");
endmodule

bind sss_axis sss_axis_props sss_axis_props_inst (
  .sys_clk   (sys_clk),
  .rst_n     (rst_n),
  .bus_wr    (bus_wr),
  .bus_rd    (bus_rd),
  .bus_addr  (bus_addr),
  .bus_rdata (bus_rdata),
  .move_req  (move_req),
  .cur_level (cur_level),
  .boost_out (boost_out),
  .cur_ready (cur_ready),
  .fault     (fault)
);

// ### sss_drive_model.sv
`timescale 1ns/1ps
module sss_drive_model
  import sss_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        move_req,
  input  wire logic [31:0] move_target,
  input  wire logic        stall,
  output logic             enc_a,
  output logic             enc_b,
  output logic             step_done
);
  // ----------------------------------------
  // drive and shaft encoder
  // ----------------------------------------
  logic [31:0] cmd;
  logic [31:0] tgt;
  logic [31:0] shaft;
  logic [31:0] dstep;
  logic [1:0]  div;
  logic        busy;

  assign dstep = ($signed(tgt) > $signed(cmd)) ? 32'h1 : 32'hffffffff;
  // a leads b when counting up
  assign enc_a = shaft[0] ^ shaft[1];
  assign enc_b = shaft[1];

  // one step per four clocks keeps every edge well past the input synchronizer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd       <= 32'h0;
      tgt       <= 32'h0;
      shaft     <= 32'h0;
      div       <= 2'h0;
      busy      <= 1'b0;
      step_done <= 1'b0;
    end else begin
      step_done <= 1'b0;
      if (move_req) begin
        tgt  <= move_target;
        busy <= 1'b1;
        div  <= 2'h0;
      end else if (busy) begin
        div <= div + 2'h1;
        if (div == 2'h3) begin
          if (cmd == tgt) begin
            busy      <= 1'b0;
            step_done <= 1'b1;
          end else begin
            cmd <= cmd + dstep;
            // a stalled rotor takes the pulses but the shaft stays put
            if (!stall) begin
              shaft <= shaft + dstep;
            end
          end
        end
      end
    end
  end
endmodule

// ### sss_axis_bench.sv
`timescale 1ns/1ps
module sss_axis_bench;
  import sss_pkg::*;
  logic         sys_clk   = 1'b0;
  logic         rst_n     = 1'b0;
  logic         bus_wr    = 1'b0;
  logic         bus_rd    = 1'b0;
  logic [7:0]   bus_addr  = 8'h00;
  logic [31:0]  bus_wdata = 32'h0;
  logic         stall     = 1'b0;
  logic [31:0]  bus_rdata;
  wire  [7:0]   enc_a;
  wire  [7:0]   enc_b;
  wire  [7:0]   step_done;
  logic [7:0]   move_req;
  logic [7:0]   boost_out;
  logic [7:0]   cur_ready;
  logic [255:0] move_target;
  logic [255:0] move_start_spd;
  logic [255:0] move_steps_rev;
  logic [15:0]  cur_level;
  logic         fault;
  logic [7:0]   winding_enable;
  int           err_count = 0;
  int           checked   = 0;
  int           moves     = 0;
  int           backs     = 0;

  // ----------------------------------------
  // clock, design and drive
  // ----------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (move_req[0] === 1'b1) moves++;
    if (move_req[0] === 1'b1 && move_target[31:0] === 32'h0) backs++;
  end
  assign enc_a[7:1]     = 7'h0;
  assign enc_b[7:1]     = 7'h0;
  assign step_done[7:1] = 7'h0;

  sss_axis sss_axis_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .enc_a(enc_a), .enc_b(enc_b),
    .step_done(step_done), .move_req(move_req), .move_target(move_target),
    .move_start_spd(move_start_spd), .move_steps_rev(move_steps_rev), .cur_level(cur_level),
    .boost_out(boost_out), .winding_enable(winding_enable), .cur_ready(cur_ready), .fault(fault));
  sss_drive_model sss_drive_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .move_req(move_req[0]),
    .move_target(move_target[31:0]), .stall(stall), .enc_a(enc_a[0]), .enc_b(enc_b[0]),
    .step_done(step_done[0]));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rst;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    stall <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  // sel 0 waits for the fault output, sel 1 for the end of a move
  task automatic wait_for(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if ((sel == 0 ? fault : step_done[0]) === 1'b1) return;
    end
    err_count++;
    $display("Error at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
    close_out();
  endtask
  function automatic logic [31:0] ctl(logic [1:0] st, logic bo, logic [1:0] ac, logic dr, logic cl);
    return {24'h0, cl, 1'b1, dr, ac, bo, st};
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults;
    logic [7:0]  ad [8] = '{REG_START_SPD, REG_STEPS_REV, REG_MOT_LIMIT, REG_STILL_LIM, REG_MAX_TRIES,
                            REG_LINES, REG_CUR_DELAY, REG_TRY_GAP};
    logic [31:0] ex [8] = '{RST_START_SPD, RST_STEPS_REV, RST_MOT_LIMIT, RST_STILL_LIM, {24'h0, RST_MAX_TRIES},
                            {16'h0, RST_LINES}, RST_CUR_DELAY, RST_TRY_GAP};
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(ad[i], d);
      check(d, ex[i]);
    end
    rd(8'hfc, d);
    check(d, 32'h0);
    wr(REG_AXIS_SEL, 32'h7);
    wr(REG_START_SPD, 32'h123);
    repeat (2) @(posedge sys_clk);
    check(move_start_spd[255:224], 32'h123);
    check(move_start_spd[31:0], RST_START_SPD);
    check(move_steps_rev[31:0], RST_STEPS_REV);
  endtask

  task automatic t_current;
    rst();
    wr(REG_CUR_DELAY, 32'ha);
    wr(REG_CTRL, ctl(SSS_STILL_HALF, 1'b1, SSS_ACT_IGNORE, 1'b0, 1'b0));
    repeat (20) @(posedge sys_clk);
    check(32'(cur_level[1:0]), 32'(SSS_CUR_HALF));
    wr(REG_MOVE, 32'h28);
    repeat (30) @(posedge sys_clk);
    check(32'(cur_level[1:0]), 32'(SSS_CUR_BOOST));
    check(32'(boost_out[0]), 32'h1);
    wait_for(1, 1000);
    repeat (20) @(posedge sys_clk);
    check(32'(boost_out[0]), 32'h0);
    wr(REG_CTRL, ctl(SSS_STILL_OFF, 1'b0, SSS_ACT_IGNORE, 1'b0, 1'b0));
    repeat (2) @(posedge sys_clk);
    check(32'(cur_ready[0]), 32'h0);
    repeat (18) @(posedge sys_clk);
    check(32'(cur_level[1:0]), 32'(SSS_CUR_OFF));
    check(32'(winding_enable[0]), 32'h0);
    wr(REG_CTRL, ctl(SSS_STILL_FULL, 1'b0, SSS_ACT_IGNORE, 1'b0, 1'b0));
    repeat (20) @(posedge sys_clk);
    check(32'(cur_level[1:0]), 32'(SSS_CUR_FULL));
    check(32'(winding_enable[0]), 32'h1);
  endtask

  // a short move stays inside the motion limit, so nothing trips
  task automatic t_encoder(input logic dir, input logic [31:0] exp);
    logic [31:0] d;
    rst();
    wr(REG_CTRL, ctl(SSS_STILL_FULL, 1'b0, SSS_ACT_IGNORE, dir, 1'b1));
    wr(REG_MOVE, 32'h32);
    wait_for(1, 1000);
    repeat (10) @(posedge sys_clk);
    rd(REG_ENC_POS, d);
    check(d, exp);
    rd(REG_CMD_POS, d);
    check(d, 32'h32);
    check(32'(fault), 32'h0);
  endtask

  task automatic t_stop;
    rst();
    stall <= 1'b1;
    wr(REG_CTRL, ctl(SSS_STILL_FULL, 1'b0, SSS_ACT_IGNORE, 1'b0, 1'b1));
    wr(REG_MOVE, 32'h12c);
    repeat (600) @(posedge sys_clk);
    check(32'(fault), 32'h0);
    wr(REG_CTRL, ctl(SSS_STILL_FULL, 1'b0, SSS_ACT_STOP, 1'b0, 1'b1));
    wait_for(0, 1000);
    check(32'(fault), 32'h1);
    wr(REG_STATUS, 32'h0);
    @(posedge sys_clk);
    check(32'(fault), 32'h0);
  endtask

  task automatic t_retry(input logic [1:0] act);
    int m;
    logic [31:0] d;
    rst();
    stall <= 1'b1;
    wr(REG_MAX_TRIES, 32'h2);
    wr(REG_TRY_GAP, 32'ha);
    wr(REG_CTRL, ctl(SSS_STILL_FULL, 1'b0, act, 1'b0, 1'b1));
    moves = 0;
    backs = 0;
    wr(REG_MOVE, 32'h12c);
    wait_for(0, 20000);
    check(32'(moves), (act == SSS_ACT_RESTART) ? 32'h5 : 32'h3);
    check(32'(backs), (act == SSS_ACT_RESTART) ? 32'h2 : 32'h0);
    m = moves;
    repeat (200) @(posedge sys_clk);
    check(32'(moves), 32'(m));
    wr(REG_MOVE, 32'h0);
    rd(REG_STATUS, d);
    check(32'(d[15:8]), 32'h0);
  endtask

  initial begin
    rst();
    t_defaults();
    t_current();
    t_encoder(1'b0, 32'h32);
    t_encoder(1'b1, 32'hffffffce);
    t_stop();
    t_retry(SSS_ACT_CORRECT);
    t_retry(SSS_ACT_RESTART);
    close_out();
  end
endmodule
